// ==== common/pru_pkg.sv ====
// Constants and types shared by the pixel rectangle unpack engine.
// Assumes a byte of eight bits; element sizes are powers of two bytes.
package pru_pkg;
  // Format codes
  localparam logic [4:0] FMT_COLOR_INDEX = 5'h00;
  localparam logic [4:0] FMT_STENCIL_INDEX = 5'h01;
  localparam logic [4:0] FMT_DEPTH = 5'h02;
  localparam logic [4:0] FMT_DEPTH_STENCIL = 5'h03;
  localparam logic [4:0] FMT_RED = 5'h04;
  localparam logic [4:0] FMT_GREEN = 5'h05;
  localparam logic [4:0] FMT_BLUE = 5'h06;
  localparam logic [4:0] FMT_ALPHA = 5'h07;
  localparam logic [4:0] FMT_RG = 5'h08;
  localparam logic [4:0] FMT_RGB = 5'h09;
  localparam logic [4:0] FMT_RGBA = 5'h0a;
  localparam logic [4:0] FMT_BGR = 5'h0b;
  localparam logic [4:0] FMT_BGRA = 5'h0c;
  localparam logic [4:0] FMT_LUM = 5'h0d;
  localparam logic [4:0] FMT_LUM_ALPHA = 5'h0e;
  localparam logic [4:0] FMT_RED_INT = 5'h0f;
  localparam logic [4:0] FMT_GREEN_INT = 5'h10;
  localparam logic [4:0] FMT_BLUE_INT = 5'h11;
  localparam logic [4:0] FMT_ALPHA_INT = 5'h12;
  localparam logic [4:0] FMT_RG_INT = 5'h13;
  localparam logic [4:0] FMT_RGB_INT = 5'h14;
  localparam logic [4:0] FMT_RGBA_INT = 5'h15;
  localparam logic [4:0] FMT_BGR_INT = 5'h16;
  localparam logic [4:0] FMT_BGRA_INT = 5'h17;
  // Type codes
  localparam logic [4:0] TYP_UBYTE = 5'h00;
  localparam logic [4:0] TYP_ONE_BIT = 5'h01;
  localparam logic [4:0] TYP_BYTE = 5'h02;
  localparam logic [4:0] TYP_USHORT = 5'h03;
  localparam logic [4:0] TYP_SHORT = 5'h04;
  localparam logic [4:0] TYP_UINT = 5'h05;
  localparam logic [4:0] TYP_INT = 5'h06;
  localparam logic [4:0] TYP_HALF = 5'h07;
  localparam logic [4:0] TYP_FLOAT = 5'h08;
  localparam logic [4:0] TYP_UB_332 = 5'h09;
  localparam logic [4:0] TYP_UB_233R = 5'h0a;
  localparam logic [4:0] TYP_US_FIRST = 5'h0b;
  localparam logic [4:0] TYP_US_LAST = 5'h10;
  localparam logic [4:0] TYP_UI_FIRST = 5'h11;
  localparam logic [4:0] TYP_UI_24_8 = 5'h15;
  localparam logic [4:0] TYP_UI_LAST = 5'h17;
  localparam logic [4:0] TYP_FLOAT_PLUS_PACKED_REV = 5'h18;
  // Element kinds
  localparam logic [2:0] KIND_U8 = 3'h0;
  localparam logic [2:0] KIND_S8 = 3'h1;
  localparam logic [2:0] KIND_U16 = 3'h2;
  localparam logic [2:0] KIND_S16 = 3'h3;
  localparam logic [2:0] KIND_U32 = 3'h4;
  localparam logic [2:0] KIND_S32 = 3'h5;
  localparam logic [2:0] KIND_HALF = 3'h6;
  localparam logic [2:0] KIND_FLOAT = 3'h7;
  // Log2 of element bytes
  localparam logic [1:0] LSZ_1 = 2'h0;
  localparam logic [1:0] LSZ_2 = 2'h1;
  localparam logic [1:0] LSZ_4 = 2'h2;
  localparam logic [3:0] FLOAT_PLUS_ALIGN_MASK = 4'h3;
  // Error codes
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_BAD_ENUM = 2'h1;
  localparam logic [1:0] ERR_BAD_OP = 2'h2;
endpackage : pru_pkg

// ==== src/pru_skid.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; synchronous active-high reset.
`timescale 1ns/100ps
module pru_skid #(
  parameter int W = 32
) (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic [W-1:0] in_data_in, // Word in
  input wire logic in_valid_in, // Word in valid
  output logic in_ready_out, // Room for a word
  output logic [W-1:0] out_data_out, // Head word
  output logic out_valid_out, // Head valid
  input wire logic out_ready_in // Receiver takes head
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic rd_q, rd_d, wr_q, wr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;
  always_comb begin
    push = in_valid_in && (cnt_q != 2'h2);
    pop = out_valid_out && out_ready_in;
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data_in;
    end
    wr_d = push ? ~wr_q : wr_q;
    rd_d = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk_in) begin
    mem_q <= mem_d;
    if (rst_in) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end
  assign in_ready_out = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign out_data_out = mem_q[rd_q];
endmodule : pru_skid

// ==== src/pru_unpack.sv ====
// Pixel rectangle unpack engine: checks, address walk, swap and grouping.
// Assumes memory answers reads in order with a valid strobe; one clock.
//
// What this block does
// - One-bit type needs an index format.
// - Depth-stencil needs one of two packed types.
// - Integer formats refuse the float type.
// - Bound buffer: offset; else client pointer.
// - Bound buffer: fetch past size is error.
// - Bound buffer: offset aligned to element size.
// - Gather one to four elements per group.
// - Decode type into element kind.
// - Swap bytes of 16 and 32 bit elements.
// - Swap leaves 8 bit elements unchanged.
// - Row length zero or less means width.
// - Row N starts at base plus N strides.
// - Stride padded up to alignment when smaller.
// - Elements at least as wide as alignment ignore it.
// - Skip pixels and rows before first group.
// - Height rows of width contiguous groups.
// - Only index formats yield indices.
// - Integer formats yield integer components.
// - No swap keeps native byte order.
`timescale 1ns/100ps
module pru_unpack #(
  parameter int AW = 32
) (
  input wire logic clk_in, // Clock, 125 MHz
  input wire logic rst_in, // Synchronous reset
  input wire logic start_in, // Command pulse
  input wire logic [4:0] format_in, // Format code
  input wire logic [4:0] type_in, // Type code
  input wire logic [15:0] width_in, // Groups per row
  input wire logic [15:0] height_in, // Rows
  input wire logic [AW-1:0] data_arg_in, // Offset or pointer
  input wire logic buf_bound_in, // Unpack buffer bound
  input wire logic [AW-1:0] buf_base_in, // Buffer byte base
  input wire logic [AW-1:0] buf_size_in, // Buffer byte size
  input wire logic signed [16:0] row_length_in, // Row length setting
  input wire logic [15:0] skip_pixels_in, // Skip pixels
  input wire logic [15:0] skip_rows_in, // Skip rows
  input wire logic [3:0] row_byte_alignment_in, // 1, 2, 4 or 8
  input wire logic swap_bytes_in, // Swap enable
  output logic busy_out, // Command running
  output logic done_out, // End pulse
  output logic [1:0] error_out, // Error of last command
  output logic rd_req_out, // Element read request
  output logic [AW-1:0] rd_addr_out, // Byte address
  output logic [1:0] rd_lsize_out, // Log2 bytes
  input wire logic rd_ready_in, // Memory takes request
  input wire logic rd_valid_in, // Element returned
  input wire logic [31:0] rd_data_in, // Element, low aligned
  output logic grp_valid_out, // Group valid
  input wire logic grp_ready_in, // Receiver ready
  output logic [127:0] grp_data_out, // Elements, first lowest
  output logic [2:0] grp_count_out, // Elements in group
  output logic [2:0] grp_kind_out, // Element kind
  output logic grp_index_out, // Values are indices
  output logic grp_integer_out // Components are integers
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_CHECK = 4'b0010, ST_FETCH = 4'b0100, ST_DRAIN = 4'b1000
  } pru_state_t;

  function automatic logic [2:0] pru_elems(input logic [4:0] f);
    unique case (f)
      pru_pkg::FMT_DEPTH_STENCIL, pru_pkg::FMT_RG, pru_pkg::FMT_LUM_ALPHA, pru_pkg::FMT_RG_INT: pru_elems = 3'h2;
      pru_pkg::FMT_RGB, pru_pkg::FMT_BGR, pru_pkg::FMT_RGB_INT, pru_pkg::FMT_BGR_INT: pru_elems = 3'h3;
      pru_pkg::FMT_RGBA, pru_pkg::FMT_BGRA, pru_pkg::FMT_RGBA_INT, pru_pkg::FMT_BGRA_INT: pru_elems = 3'h4;
      default: pru_elems = 3'h1;
    endcase
  endfunction : pru_elems

  function automatic logic pru_int_fmt(input logic [4:0] f);
    pru_int_fmt = (f >= pru_pkg::FMT_RED_INT) && (f <= pru_pkg::FMT_BGRA_INT);
  endfunction : pru_int_fmt

  function automatic logic [2:0] pru_kind(input logic [4:0] t);
    if (t == pru_pkg::TYP_BYTE) pru_kind = pru_pkg::KIND_S8;
    else if (t == pru_pkg::TYP_USHORT) pru_kind = pru_pkg::KIND_U16;
    else if (t == pru_pkg::TYP_SHORT) pru_kind = pru_pkg::KIND_S16;
    else if (t == pru_pkg::TYP_UINT) pru_kind = pru_pkg::KIND_U32;
    else if (t == pru_pkg::TYP_INT) pru_kind = pru_pkg::KIND_S32;
    else if (t == pru_pkg::TYP_HALF) pru_kind = pru_pkg::KIND_HALF;
    else if (t == pru_pkg::TYP_FLOAT) pru_kind = pru_pkg::KIND_FLOAT;
    else if (t >= pru_pkg::TYP_US_FIRST && t <= pru_pkg::TYP_US_LAST) pru_kind = pru_pkg::KIND_U16;
    else if (t >= pru_pkg::TYP_UI_FIRST) pru_kind = pru_pkg::KIND_U32;
    else pru_kind = pru_pkg::KIND_U8;
  endfunction : pru_kind

  function automatic logic [1:0] pru_lsize(input logic [2:0] k);
    unique case (k)
      pru_pkg::KIND_U8, pru_pkg::KIND_S8: pru_lsize = pru_pkg::LSZ_1;
      pru_pkg::KIND_U16, pru_pkg::KIND_S16, pru_pkg::KIND_HALF: pru_lsize = pru_pkg::LSZ_2;
      default: pru_lsize = pru_pkg::LSZ_4;
    endcase
  endfunction : pru_lsize

  function automatic logic [31:0] pru_swap(input logic [31:0] v, input logic [1:0] ls, input logic en);
    if (!en || ls == pru_pkg::LSZ_1) pru_swap = v;
    else if (ls == pru_pkg::LSZ_2) pru_swap = {16'h0000, v[7:0], v[15:8]};
    else pru_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : pru_swap

  pru_state_t st_q, st_d;
  logic [4:0] fmt_q, fmt_d, typ_q, typ_d;
  logic [2:0] n_q, n_d, kind_q, kind_d;
  logic [1:0] ls_q, ls_d, err_q, err_d;
  logic swap_q, swap_d, bound_q, bound_d, done_q, done_d;
  logic [AW-1:0] row_q, row_d, ptr_q, ptr_d, stride_q, stride_d, base_q, base_d, lim_q, lim_d;
  logic [AW-1:0] arg_q, arg_d;
  logic [15:0] w_q, w_d, h_q, h_d, gcol_q, gcol_d, grow_q, grow_d;
  logic [2:0] ecnt_q, ecnt_d, acnt_q, acnt_d;
  logic [15:0] sp_q, sp_d, sr_q, sr_d;
  logic [AW-1:0] l_q, l_d;
  logic [3:0] al_q, al_d;
  logic [31:0] outstanding_q, outstanding_d;
  logic [127:0] asm_q, asm_d;
  logic push_valid, push_ready;
  logic [135:0] push_word, pop_word;
  logic [AW-1:0] row_elems, pad_bytes, first_ptr, last_byte;
  logic [AW-1:0] amask;

  always_comb begin
    st_d = st_q; fmt_d = fmt_q; typ_d = typ_q; n_d = n_q; kind_d = kind_q; ls_d = ls_q;
    err_d = err_q; swap_d = swap_q; bound_d = bound_q; done_d = 1'b0;
    row_d = row_q; ptr_d = ptr_q; stride_d = stride_q; base_d = base_q; lim_d = lim_q; arg_d = arg_q;
    w_d = w_q; h_d = h_q; gcol_d = gcol_q; grow_d = grow_q; ecnt_d = ecnt_q;
    sp_d = sp_q; sr_d = sr_q; l_d = l_q; al_d = al_q;
    // Stride in bytes: row bytes, padded to alignment only when elements are narrower
    row_elems = l_q * AW'(n_q);
    pad_bytes = row_elems << ls_q;
    amask = AW'(al_q) - AW'(1);
    if ((AW'(1) << ls_q) < AW'(al_q)) begin
      pad_bytes = (pad_bytes + amask) & ~amask;
    end
    first_ptr = arg_q + ((AW'(sp_q) * AW'(n_q)) << ls_q) + AW'(sr_q) * pad_bytes;
    last_byte = first_ptr + AW'(h_q - 16'h1) * pad_bytes + ((AW'(w_q) * AW'(n_q)) << ls_q) - AW'(1);
    unique case (st_q)
      ST_IDLE: begin
        if (start_in) begin
          fmt_d = format_in; typ_d = type_in; w_d = width_in; h_d = height_in;
          arg_d = data_arg_in; bound_d = buf_bound_in; swap_d = swap_bytes_in;
          sp_d = skip_pixels_in; sr_d = skip_rows_in; al_d = row_byte_alignment_in;
          l_d = (row_length_in <= 17'sh0) ? AW'(width_in) : AW'(row_length_in[15:0]);
          n_d = pru_elems(format_in);
          kind_d = pru_kind(type_in);
          ls_d = pru_lsize(pru_kind(type_in));
          base_d = buf_bound_in ? buf_base_in : '0;
          lim_d = buf_size_in;
          err_d = pru_pkg::ERR_NONE;
          st_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        stride_d = pad_bytes;
        row_d = first_ptr; ptr_d = first_ptr; gcol_d = 16'h0; grow_d = 16'h0; ecnt_d = 3'h0;
        st_d = ST_FETCH;
        if (typ_q == pru_pkg::TYP_ONE_BIT && fmt_q != pru_pkg::FMT_COLOR_INDEX
            && fmt_q != pru_pkg::FMT_STENCIL_INDEX) begin
          err_d = pru_pkg::ERR_BAD_ENUM;
        end else if (fmt_q == pru_pkg::FMT_DEPTH_STENCIL && typ_q != pru_pkg::TYP_UI_24_8
                     && typ_q != pru_pkg::TYP_FLOAT_PLUS_PACKED_REV) begin
          err_d = pru_pkg::ERR_BAD_ENUM;
        end else if (pru_int_fmt(fmt_q) && typ_q == pru_pkg::TYP_FLOAT) begin
          err_d = pru_pkg::ERR_BAD_ENUM;
        end else if (bound_q && ((typ_q == pru_pkg::TYP_FLOAT_PLUS_PACKED_REV)
                     ? ((arg_q & AW'(pru_pkg::FLOAT_PLUS_ALIGN_MASK)) != '0)
                     : ((arg_q & ((AW'(1) << ls_q) - AW'(1))) != '0))) begin
          err_d = pru_pkg::ERR_BAD_OP;
        end else if (bound_q && w_q != 16'h0 && h_q != 16'h0 && last_byte >= lim_q) begin
          err_d = pru_pkg::ERR_BAD_OP;
        end
        if (err_d != pru_pkg::ERR_NONE || w_q == 16'h0 || h_q == 16'h0) begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      ST_FETCH: begin
        if (rd_req_out && rd_ready_in) begin
          ptr_d = ptr_q + (AW'(1) << ls_q);
          if (ecnt_q == n_q - 3'h1) begin
            ecnt_d = 3'h0;
            if (gcol_q == w_q - 16'h1) begin
              gcol_d = 16'h0;
              grow_d = grow_q + 16'h1;
              row_d = row_q + stride_q;
              ptr_d = row_q + stride_q;
            end else begin
              gcol_d = gcol_q + 16'h1;
            end
          end else begin
            ecnt_d = ecnt_q + 3'h1;
          end
        end
        if (grow_q == h_q) begin
          st_d = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (outstanding_q == 32'h0 && acnt_q == 3'h0) begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Assembly: one group in flight at most, so the buffer never overflows
  always_comb begin
    asm_d = asm_q; acnt_d = acnt_q; outstanding_d = outstanding_q;
    push_valid = 1'b0;
    if (rd_req_out && rd_ready_in) outstanding_d = outstanding_d + 32'h1;
    if (rd_valid_in) begin
      outstanding_d = outstanding_d - 32'h1;
      asm_d[acnt_q*32 +: 32] = pru_swap(rd_data_in, ls_q, swap_q);
      acnt_d = acnt_q + 3'h1;
    end
    if (acnt_q == n_q && n_q != 3'h0) begin
      push_valid = 1'b1;
      if (push_ready) begin
        acnt_d = 3'h0;
        asm_d = '0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE; fmt_q <= '0; typ_q <= '0; n_q <= 3'h1; kind_q <= '0; ls_q <= '0;
      err_q <= pru_pkg::ERR_NONE; swap_q <= 1'b0; bound_q <= 1'b0; done_q <= 1'b0;
      row_q <= '0; ptr_q <= '0; stride_q <= '0; base_q <= '0; lim_q <= '0; arg_q <= '0;
      w_q <= '0; h_q <= '0; gcol_q <= '0; grow_q <= '0; ecnt_q <= '0;
      sp_q <= '0; sr_q <= '0; l_q <= '0; al_q <= 4'h1;
      asm_q <= '0; acnt_q <= '0; outstanding_q <= '0;
    end else begin
      st_q <= st_d; fmt_q <= fmt_d; typ_q <= typ_d; n_q <= n_d; kind_q <= kind_d; ls_q <= ls_d;
      err_q <= err_d; swap_q <= swap_d; bound_q <= bound_d; done_q <= done_d;
      row_q <= row_d; ptr_q <= ptr_d; stride_q <= stride_d; base_q <= base_d; lim_q <= lim_d;
      arg_q <= arg_d; w_q <= w_d; h_q <= h_d; gcol_q <= gcol_d; grow_q <= grow_d; ecnt_q <= ecnt_d;
      sp_q <= sp_d; sr_q <= sr_d; l_q <= l_d; al_q <= al_d;
      asm_q <= asm_d; acnt_q <= acnt_d; outstanding_q <= outstanding_d;
    end
  end

  // Requests issue for one group, then wait until it is assembled
  logic req_hold_q;
  logic req_hold_d;
  always_comb begin
    req_hold_d = req_hold_q;
    if (rd_req_out && rd_ready_in && ecnt_q == n_q - 3'h1) req_hold_d = 1'b1;
    if (acnt_q == 3'h0 && outstanding_q == 32'h0 && !(rd_req_out && rd_ready_in)) req_hold_d = 1'b0;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) req_hold_q <= 1'b0;
    else req_hold_q <= req_hold_d;
  end
  assign rd_req_out = (st_q == ST_FETCH) && (grow_q != h_q) && !req_hold_q && push_ready;
  assign rd_addr_out = base_q + ptr_q;
  assign rd_lsize_out = ls_q;

  // Integer tag travels with the group, so a new command cannot retag a buffered one
  assign push_word = {pru_int_fmt(fmt_q), kind_q, n_q,
                      (fmt_q == pru_pkg::FMT_COLOR_INDEX || fmt_q == pru_pkg::FMT_STENCIL_INDEX), asm_q};
  pru_skid #(.W(136)) u_skid (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_data_in(push_word),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .out_data_out(pop_word),
    .out_valid_out(grp_valid_out),
    .out_ready_in(grp_ready_in)
  );
  assign grp_data_out = pop_word[127:0];
  assign grp_index_out = pop_word[128];
  assign grp_count_out = pop_word[131:129];
  assign grp_kind_out = pop_word[134:132];
  assign grp_integer_out = !pop_word[128] && pop_word[135];
  assign busy_out = (st_q != ST_IDLE);
  assign done_out = done_q;
  assign error_out = err_q;

  a_no_fetch_on_err: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == ST_CHECK && err_d != pru_pkg::ERR_NONE) |=> !rd_req_out [*2]) else $error("fetch after failed check");
  a_enum_onebit: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == ST_CHECK && typ_q == pru_pkg::TYP_ONE_BIT && fmt_q > pru_pkg::FMT_STENCIL_INDEX)
    |=> error_out == pru_pkg::ERR_BAD_ENUM && done_out) else $error("one-bit type check missed");
  a_enum_depst: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == ST_CHECK && fmt_q == pru_pkg::FMT_DEPTH_STENCIL && typ_q == pru_pkg::TYP_UBYTE)
    |=> error_out == pru_pkg::ERR_BAD_ENUM) else $error("depth-stencil type check missed");
  a_enum_intflt: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == ST_CHECK && pru_int_fmt(fmt_q) && typ_q == pru_pkg::TYP_FLOAT)
    |=> error_out == pru_pkg::ERR_BAD_ENUM) else $error("integer float check missed");
  a_align_off: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == ST_CHECK && bound_q && ls_q != pru_pkg::LSZ_1 && arg_q[0] && err_d != pru_pkg::ERR_BAD_ENUM)
    |=> error_out == pru_pkg::ERR_BAD_OP) else $error("offset alignment check missed");
  a_bound_size: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_req_out && bound_q |-> ptr_q < lim_q) else $error("fetch beyond buffer");
  a_row_step: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_req_out && rd_ready_in && ecnt_q == n_q - 3'h1 && gcol_q == w_q - 16'h1)
    |=> ptr_q == $past(row_q) + stride_q) else $error("row stride step wrong");
  a_swap_16: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_valid_in && swap_q && ls_q == pru_pkg::LSZ_2 && acnt_q == 3'h0)
    |=> asm_q[15:0] == {$past(rd_data_in[7:0]), $past(rd_data_in[15:8])}) else $error("16-bit swap wrong");
endmodule : pru_unpack

// ==== verif/pru_mem_model.sv ====
// Memory model that answers element reads of the unpack engine.
// Assumes a request is held until taken; answers come in order, at most one a cycle.
`timescale 1ns/100ps
module pru_mem_model (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic slow_in, // Stall ready and answers
  input wire logic rd_req_in, // Read request
  input wire logic [31:0] rd_addr_in, // Byte address
  input wire logic [1:0] rd_lsize_in, // Log2 bytes
  output logic rd_ready_out, // Request taken
  output logic rd_valid_out, // Element returned
  output logic [31:0] rd_data_out, // Element, low aligned
  output int reads_out // Reads taken
);
  logic [31:0] q[$];
  logic [31:0] v;
  logic [1:0] ph;
  always @(posedge clk_in) begin
    if (rst_in) begin
      q.delete();
      ph <= 2'h0;
      reads_out <= 0;
      rd_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 32'h0;
    end else begin
      ph <= ph + 2'h1;
      rd_ready_out <= !slow_in || ph[0];
      if (rd_req_in && rd_ready_out) begin
        v = 32'h0;
        // Native order: lowest address in the lowest byte
        for (int i = 0; i < (1 << rd_lsize_in); i++) begin
          v[8*i+:8] = rd_addr_in[7:0] + i[7:0] ^ rd_addr_in[15:8];
        end
        q.push_back(v);
        reads_out <= reads_out + 1;
      end
      rd_valid_out <= 1'b0;
      // A line not carrying data toggles so stale values never pass
      rd_data_out <= ~rd_data_out;
      if (q.size() > 0 && (!slow_in || ph[1])) begin
        rd_data_out <= q.pop_front();
        rd_valid_out <= 1'b1;
      end
    end
  end
endmodule : pru_mem_model

// ==== verif/pru_unpack_bench.sv ====
// Self-checking bench of the pixel rectangle unpack engine.
// Assumes pru_pkg codes and the memory model beside it.
`timescale 1ns/100ps
module pru_unpack_bench;
  logic clk_in = 0, rst_in = 1, start = 0, bnd = 0, sw = 0, slow = 0, grp_ready_in = 0;
  logic [4:0] fmt = 0, typ = 0;
  logic [15:0] w = 0, h = 0, sp = 0, sr = 0;
  logic signed [16:0] rl = 0;
  logic [3:0] al = 1;
  logic [31:0] arg = 0, sz = 0, ra, rd;
  logic busy, done, rq, rrdy, rv, gv, gx, gint;
  logic [1:0] err, rls;
  logic [127:0] gd;
  logic [2:0] gc, gk;
  int reads, bad_count = 0, comparisons = 0, cyc = 0;
  logic [2:0] kd[9] = '{pru_pkg::KIND_U8, pru_pkg::KIND_U8, pru_pkg::KIND_S8, pru_pkg::KIND_U16,
    pru_pkg::KIND_S16, pru_pkg::KIND_U32, pru_pkg::KIND_S32, pru_pkg::KIND_HALF, pru_pkg::KIND_FLOAT};
  int sz_of[9] = '{1, 1, 1, 2, 2, 4, 4, 2, 4};
  pru_unpack i_dut (.clk_in(clk_in), .rst_in(rst_in), .start_in(start), .format_in(fmt), .type_in(typ),
    .width_in(w), .height_in(h), .data_arg_in(arg), .buf_bound_in(bnd), .buf_base_in(32'h1000),
    .buf_size_in(sz), .row_length_in(rl), .skip_pixels_in(sp), .skip_rows_in(sr),
    .row_byte_alignment_in(al), .swap_bytes_in(sw), .busy_out(busy), .done_out(done), .error_out(err),
    .rd_req_out(rq), .rd_addr_out(ra), .rd_lsize_out(rls), .rd_ready_in(rrdy), .rd_valid_in(rv),
    .rd_data_in(rd), .grp_valid_out(gv), .grp_ready_in(grp_ready_in), .grp_data_out(gd),
    .grp_count_out(gc), .grp_kind_out(gk), .grp_index_out(gx), .grp_integer_out(gint));
  pru_mem_model i_mem (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow), .rd_req_in(rq), .rd_addr_in(ra),
    .rd_lsize_in(rls), .rd_ready_out(rrdy), .rd_valid_out(rv), .rd_data_out(rd), .reads_out(reads));
  always #4 clk_in = ~clk_in;
  // Receiver stalls one cycle in four; the cycle ceiling cuts a hang short
  always @(posedge clk_in) begin
    #1 cyc = cyc + 1;
    grp_ready_in = cyc[1:0] != 2'h0;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  task results;
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [127:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] ev(input logic [31:0] a, input int s, input bit x);
    logic [31:0] v = 32'h0;
    for (int i = 0; i < s; i++) v[8*(x ? s-1-i : i)+:8] = a[7:0] + i[7:0] ^ a[15:8];
    return v;
  endfunction : ev
  function automatic int nf(input logic [4:0] f);
    case (f)
      pru_pkg::FMT_RG, pru_pkg::FMT_LUM_ALPHA, pru_pkg::FMT_RG_INT, pru_pkg::FMT_DEPTH_STENCIL: return 2;
      pru_pkg::FMT_RGB, pru_pkg::FMT_BGR, pru_pkg::FMT_RGB_INT, pru_pkg::FMT_BGR_INT: return 3;
      pru_pkg::FMT_RGBA, pru_pkg::FMT_BGRA, pru_pkg::FMT_RGBA_INT, pru_pkg::FMT_BGRA_INT: return 4;
      default: return 1;
    endcase
  endfunction : nf
  task automatic cmd(input logic [4:0] f, t, input logic [15:0] ww, hh, input logic signed [16:0] r,
                     input logic [15:0] p, q, input logic [3:0] a, input bit s, b, input logic [31:0] o, z);
    while (busy) @(posedge clk_in);
    @(posedge clk_in);
    #1 {fmt, typ, w, h, rl, sp, sr, al, sw, bnd, arg, sz, start} = {f, t, ww, hh, r, p, q, a, s, b, o, z, 1'b1};
    @(posedge clk_in);
    #1 start = 0;
  endtask : cmd
  // A refused or empty command ends with its error code and no read at all
  task automatic t_err(input logic [4:0] f, t, input logic [15:0] ww, input bit b, input logic [31:0] o, z,
                       input logic [1:0] e);
    int rd0;
    bit dn = 0;
    rd0 = reads;
    cmd(f, t, ww, 16'h2, 17'sh0, 16'h0, 16'h0, 4'h1, 1'b0, b, o, z);
    // Sample between edges, where launched outputs have settled
    repeat (40) if (!dn) begin
      @(negedge clk_in);
      dn = done;
    end
    chk(dn, 1);
    chk(err, e);
    // A stray read would show in the model's count only a cycle or two later
    repeat (2) @(negedge clk_in);
    chk(reads, rd0);
  endtask : t_err
  task automatic t_xfer(input logic [4:0] f, t, input logic [15:0] ww, hh, input logic signed [16:0] r,
                        input logic [15:0] p, q, input logic [3:0] a, input bit x, b, input logic [31:0] o, z,
                        input bit sl);
    int n, s, l, kb, gi, rd0, ad;
    bit dn = 0;
    slow = sl;
    n = nf(f);
    s = sz_of[t];
    l = r > 0 ? int'(r) : int'(ww);
    kb = (s >= a) ? n * l * s : (n * l * s + a - 1) / a * a;
    rd0 = reads;
    gi = 0;
    cmd(f, t, ww, hh, r, p, q, a, x, b, o, z);
    repeat (3000) if (!dn) begin
      @(negedge clk_in);
      if (gv && grp_ready_in) begin
        for (int e = 0; e < n; e++) begin
          ad = (b ? 32'h1000 : 0) + o + ((p + gi % ww) * n + e) * s + (q + gi / ww) * kb;
          chk(gd[32*e+:32], ev(ad, s, x));
        end
        chk({gc, gk, gx, gint}, {n[2:0], kd[t], f <= pru_pkg::FMT_STENCIL_INDEX, f >= pru_pkg::FMT_RED_INT});
        gi++;
      end
      dn = done;
    end
    chk({dn, err, busy}, {1'b1, pru_pkg::ERR_NONE, 1'b0});
    chk(gi, ww * hh);
    chk(reads - rd0, ww * hh * n);
  endtask : t_xfer
  task t_checks;
    t_err(pru_pkg::FMT_RGBA, pru_pkg::TYP_ONE_BIT, 2, 0, 0, 0, pru_pkg::ERR_BAD_ENUM);
    t_err(pru_pkg::FMT_DEPTH, pru_pkg::TYP_ONE_BIT, 2, 0, 0, 0, pru_pkg::ERR_BAD_ENUM);
    t_err(pru_pkg::FMT_COLOR_INDEX, pru_pkg::TYP_ONE_BIT, 0, 0, 0, 0, pru_pkg::ERR_NONE);
    t_err(pru_pkg::FMT_STENCIL_INDEX, pru_pkg::TYP_ONE_BIT, 0, 0, 0, 0, pru_pkg::ERR_NONE);
    t_err(pru_pkg::FMT_DEPTH_STENCIL, pru_pkg::TYP_UBYTE, 2, 0, 0, 0, pru_pkg::ERR_BAD_ENUM);
    t_err(pru_pkg::FMT_DEPTH_STENCIL, pru_pkg::TYP_FLOAT, 2, 0, 0, 0, pru_pkg::ERR_BAD_ENUM);
    t_err(pru_pkg::FMT_DEPTH_STENCIL, pru_pkg::TYP_UI_24_8, 0, 0, 0, 0, pru_pkg::ERR_NONE);
    t_err(pru_pkg::FMT_DEPTH_STENCIL, pru_pkg::TYP_FLOAT_PLUS_PACKED_REV, 0, 0, 0, 0, pru_pkg::ERR_NONE);
    t_err(pru_pkg::FMT_RED_INT, pru_pkg::TYP_FLOAT, 2, 0, 0, 0, pru_pkg::ERR_BAD_ENUM);
    t_err(pru_pkg::FMT_BGRA_INT, pru_pkg::TYP_FLOAT, 2, 0, 0, 0, pru_pkg::ERR_BAD_ENUM);
    t_err(pru_pkg::FMT_RGBA_INT, pru_pkg::TYP_UINT, 0, 0, 0, 0, pru_pkg::ERR_NONE);
  endtask : t_checks
  // Misaligned offsets and a buffer one byte short of the last element
  task t_bounds;
    t_err(pru_pkg::FMT_RGB, pru_pkg::TYP_USHORT, 2, 1, 1, 32'h100, pru_pkg::ERR_BAD_OP);
    t_err(pru_pkg::FMT_DEPTH_STENCIL, pru_pkg::TYP_FLOAT_PLUS_PACKED_REV, 2, 1, 2, 32'h100, pru_pkg::ERR_BAD_OP);
    t_err(pru_pkg::FMT_BGR_INT, pru_pkg::TYP_SHORT, 2, 1, 4, 27, pru_pkg::ERR_BAD_OP);
  endtask : t_bounds
  task t_walks;
    t_xfer(pru_pkg::FMT_RGBA, pru_pkg::TYP_UBYTE, 3, 2, 0, 0, 0, 4, 1, 0, 32'h100, 0, 0);
    t_xfer(pru_pkg::FMT_RGB, pru_pkg::TYP_USHORT, 2, 3, 5, 1, 1, 8, 0, 0, 32'h202, 0, 1);
    t_xfer(pru_pkg::FMT_BGR_INT, pru_pkg::TYP_SHORT, 2, 2, 0, 0, 0, 1, 1, 1, 4, 28, 0);
    t_xfer(pru_pkg::FMT_RG_INT, pru_pkg::TYP_INT, 1, 2, -3, 0, 0, 2, 1, 0, 32'h300, 0, 1);
    t_xfer(pru_pkg::FMT_COLOR_INDEX, pru_pkg::TYP_BYTE, 4, 1, 0, 0, 0, 8, 0, 0, 32'h400, 0, 1);
    t_xfer(pru_pkg::FMT_LUM_ALPHA, pru_pkg::TYP_HALF, 2, 1, 0, 0, 0, 4, 1, 0, 32'h500, 0, 0);
    t_xfer(pru_pkg::FMT_BGRA, pru_pkg::TYP_FLOAT, 1, 2, 0, 0, 1, 8, 1, 0, 32'h600, 0, 0);
    t_xfer(pru_pkg::FMT_RED, pru_pkg::TYP_UINT, 2, 1, 0, 2, 0, 4, 0, 0, 32'h700, 0, 1);
  endtask : t_walks
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_in = 0;
    t_checks();
    t_bounds();
    t_walks();
    results();
  end
endmodule : pru_unpack_bench
